/* File: pkg/dpf_defines.svh */
`ifndef DPF_DEFINES_SVH
`define DPF_DEFINES_SVH

// Device register indices on the partition-controller interface
`define DPF_RA_CTRL       3'h0
`define DPF_RA_KEY        3'h1
`define DPF_RA_SRC        3'h2
`define DPF_RA_ADDR_LO    3'h3
`define DPF_RA_ADDR_HI    3'h4
`define DPF_RA_BLIM       3'h5

// Control register fields
`define DPF_CTRL_OP_LSB   0
`define DPF_CTRL_OP_MSB   3
`define DPF_CTRL_PRIV     8
`define DPF_CTRL_PROT     9
`define DPF_CTRL_P2ACT    10
`define DPF_CTRL_SWDONE   11
`define DPF_CTRL_ERR      14
`define DPF_CTRL_START    15

// Flash operation select codes
`define DPF_OP_NOP        4'h0
`define DPF_OP_ROW_PROG   4'h2
`define DPF_OP_PAGE_ERASE 4'h3
`define DPF_OP_PART_ERASE 4'h4

// Unlock key values
`define DPF_KEY_FIRST     8'h55
`define DPF_KEY_SECOND    8'haa

// Partition addressing
`define DPF_PART_OFS      24'h400000
`define DPF_PART_SEL_BIT  22
`define DPF_PART_OFS_HI   16'h0040

// Boot sequence word layout
`define DPF_SEQ_TRUE_MSB  11
`define DPF_SEQ_TRUE_LSB  0
`define DPF_SEQ_COMP_MSB  23
`define DPF_SEQ_COMP_LSB  12

// Reset values
`define DPF_RST_KEY       16'h0000
`define DPF_RST_SRC       16'h0000
`define DPF_RST_BLIM      16'h0000

// Cycles one flash operation keeps the device busy
`define DPF_OP_CYCLES     16

// Controller APB map
`define DPF_HA_WRITE      8'h00
`define DPF_HA_READ       8'h04
`define DPF_HA_SWAP       8'h08
`define DPF_HA_STATUS     8'h0c
`define DPF_HA_IRQ_STAT   8'h10
`define DPF_HA_IRQ_CLR    8'h14
`define DPF_HA_IRQ_EN     8'h18

// Controller command fields
`define DPF_HC_ADDR_LSB   16
`define DPF_HC_ADDR_MSB   18
`define DPF_HC_INACT_BIT  19

// Interrupt bits
`define DPF_IRQ_DONE      0
`define DPF_IRQ_OPEND     1
`define DPF_IRQ_SWAP      2

`endif

/* File: pkg/dpf_pkg.sv */
package dpf_pkg;

  typedef enum logic [2:0] {
    DPF_UL_IDLE  = 3'b001,
    DPF_UL_GOT1  = 3'b010,
    DPF_UL_ARMED = 3'b100
  } dpf_unlock_t;

  typedef enum logic [2:0] {
    DPF_H_IDLE = 3'b001,
    DPF_H_WAIT = 3'b010,
    DPF_H_SWAP = 3'b100
  } dpf_hstate_t;

  typedef struct packed {
    logic        init_done;
    logic        active_p2;
    logic        prot;
    logic        priv;
    dpf_unlock_t ul;
    logic [3:0]  op;
    logic        busy;
    logic        err;
    logic        swap_done;
    logic [23:0] addr;
    logic [15:0] src;
    logic [15:0] blim;
    logic [15:0] cnt;
    logic        ack;
    logic [15:0] rdata;
    logic        ers_page;
    logic        ers_part;
    logic        prog_row;
    logic        op_part2;
  } dpf_dev_st_t;

  typedef struct packed {
    dpf_hstate_t st;
    logic        req;
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] data;
    logic        swap;
    logic        jump;
    logic [15:0] last_rd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  irq_st;
    logic [2:0]  irq_en;
    logic        irq;
    logic        busy_q;
    logic        swap_q;
  } dpf_host_st_t;

endpackage

/* File: pkg/dpf_if.sv */
`timescale 1ns/1ps
interface dpf_if;
  logic        req;           // Register access strobe, one cycle
  logic        wr;            // Access is a write
  logic [2:0]  addr;          // Register index
  logic [15:0] wdata;         // Write data
  logic        ack;           // Access answered, one cycle
  logic [15:0] rdata;         // Read data, valid with ack
  logic        swap_instr;    // Partition swap instruction executed
  logic        jump_instr;    // Jump that follows the swap
  logic        dev_busy;      // Flash operation in progress
  logic        dev_swap_done; // Soft swap done flag
  logic        dev_active_p2; // Second partition active flag

  modport dev (
    input  req, wr, addr, wdata, swap_instr, jump_instr,
    output ack, rdata, dev_busy, dev_swap_done, dev_active_p2
  );
  modport host (
    output req, wr, addr, wdata, swap_instr, jump_instr,
    input  ack, rdata, dev_busy, dev_swap_done, dev_active_p2
  );
endinterface

/* File: logic/dpf_dev.sv */
// What this block does
// R1 - Inactive partition writable without stalling fetch
// R2 - Operation select offers whole inactive partition erase
// R3 - Firmware adds 0x400000 for inactive partition images
// R4 - Boot sequence word: 24 bits, 12-bit number
// R5 - True in 11:0, complement in 23:12
// R6 - Reset activates partition with lower valid number
// R7 - One invalid picks other; both invalid partition 1
// R8 - Swap instruction exchanges partitions, jump follows it
// R9 - Software writes 0x55 then 0xAA first
// R10 - Swap without unlock acts as no-operation
// R11 - Soft swap keeps state, no configuration reload
// R12 - Swap sets done flag; active flag shown
// R13 - Software disables interrupts around the swap
// R14 - Protected mode blocks erase/write of partition 1
// R15 - Privileged mode locks boot segment limit writes
// R16 - Key register write-only, low byte, reads zero
// R17 - Row source pointer holds 16-bit RAM address
// R18 - Unlock needs consecutive key writes, then swap
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "dpf_defines.svh"
module dpf_dev #(
  parameter int OP_CYCLES = `DPF_OP_CYCLES
) (
  input  wire logic        pclk,             // System clock
  input  wire logic        presetn,          // Async reset, active low
  input  wire logic        ce,               // Clock enable
  input  wire logic [23:0] seq_word_p1,      // Partition 1 boot sequence word
  input  wire logic [23:0] seq_word_p2,      // Partition 2 boot sequence word
  input  wire logic        mode_protected,   // Protected dual partition strap
  input  wire logic        mode_privileged,  // Privileged dual partition strap
  dpf_if.dev               bus,              // Core side
  output logic             active_p2,        // Partition 2 is active
  output logic             flash_page_erase, // Page erase start pulse
  output logic             flash_part_erase, // Partition erase start pulse
  output logic             flash_row_prog,   // Row program start pulse
  output logic             flash_op_part2,   // Operation targets partition 2
  output logic [23:0]      flash_op_addr,    // Operation address
  output logic [15:0]      flash_src_addr,   // RAM source of row data
  output logic [15:0]      boot_limit        // Boot segment limit
);

  if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_bad_cycles
    $error("dpf_dev: OP_CYCLES out of range");
  end

  localparam logic [15:0] OP_CNT = 16'(OP_CYCLES);

  dpf_pkg::dpf_dev_st_t s_r;
  dpf_pkg::dpf_dev_st_t s_nxt;

  function automatic logic seq_ok(input logic [23:0] w);
    seq_ok = (w[`DPF_SEQ_COMP_MSB:`DPF_SEQ_COMP_LSB] ==
              ~w[`DPF_SEQ_TRUE_MSB:`DPF_SEQ_TRUE_LSB]); // see R5
  endfunction

  function automatic logic pick_p2(input logic [23:0] w1,
                                   input logic [23:0] w2);
    logic v1;
    logic v2;
    v1 = seq_ok(w1);
    v2 = seq_ok(w2);
    if (v1 && v2)
      pick_p2 = (w2[`DPF_SEQ_TRUE_MSB:`DPF_SEQ_TRUE_LSB] <
                 w1[`DPF_SEQ_TRUE_MSB:`DPF_SEQ_TRUE_LSB]); // see R6
    else
      pick_p2 = v2 && !v1; // see R7
  endfunction

  always_comb begin
    logic tgt_p2;
    logic start_ok;
    tgt_p2   = ~s_r.active_p2;
    start_ok = 1'b0;
    s_nxt = s_r;
    s_nxt.ack      = 1'b0;
    s_nxt.ers_page = 1'b0;
    s_nxt.ers_part = 1'b0;
    s_nxt.prog_row = 1'b0;
    if (!s_r.init_done) begin
      // Straps and sequence words are caught once, after reset release
      s_nxt.init_done = 1'b1;
      s_nxt.active_p2 = pick_p2(seq_word_p1, seq_word_p2); // see R4
      s_nxt.prot      = mode_protected;
      s_nxt.priv      = mode_privileged;
    end else begin
      if (s_r.busy) begin
        if (s_r.cnt == 16'h0001)
          s_nxt.busy = 1'b0;
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
      if (bus.req) begin
        s_nxt.ack = 1'b1;
        // Anything but the expected key write breaks the sequence
        s_nxt.ul  = dpf_pkg::DPF_UL_IDLE; // see R18
        if (bus.wr) begin
          case (bus.addr)
            `DPF_RA_KEY: begin
              if (bus.wdata[7:0] == `DPF_KEY_FIRST)
                s_nxt.ul = dpf_pkg::DPF_UL_GOT1; // see R18
              else if (bus.wdata[7:0] == `DPF_KEY_SECOND &&
                       s_r.ul == dpf_pkg::DPF_UL_GOT1)
                s_nxt.ul = dpf_pkg::DPF_UL_ARMED; // see R18
            end
            `DPF_RA_CTRL: begin
              if (!bus.wdata[`DPF_CTRL_SWDONE])
                s_nxt.swap_done = 1'b0; // see R12
              if (bus.wdata[`DPF_CTRL_START] && !s_r.busy) begin
                s_nxt.op  = bus.wdata[`DPF_CTRL_OP_MSB:`DPF_CTRL_OP_LSB];
                s_nxt.err = 1'b0;
                case (s_nxt.op)
                  `DPF_OP_PART_ERASE:
                    start_ok = 1'b1; // see R2
                  `DPF_OP_ROW_PROG, `DPF_OP_PAGE_ERASE:
                    // Active partition is fetched from, so only the
                    // inactive half may be touched
                    start_ok = s_r.addr[`DPF_PART_SEL_BIT]; // see R1
                  default:
                    start_ok = 1'b0;
                endcase
                if (s_r.prot && !tgt_p2)
                  start_ok = 1'b0; // see R14
                if (start_ok) begin
                  s_nxt.busy     = 1'b1;
                  s_nxt.cnt      = OP_CNT;
                  s_nxt.op_part2 = tgt_p2;
                  s_nxt.ers_part = (s_nxt.op == `DPF_OP_PART_ERASE);
                  s_nxt.ers_page = (s_nxt.op == `DPF_OP_PAGE_ERASE);
                  s_nxt.prog_row = (s_nxt.op == `DPF_OP_ROW_PROG); // see R17
                end else if (s_nxt.op != `DPF_OP_NOP) begin
                  s_nxt.err = 1'b1;
                end
              end
            end
            `DPF_RA_SRC: begin
              if (!s_r.busy)
                s_nxt.src = bus.wdata; // see R17
            end
            `DPF_RA_ADDR_LO: begin
              if (!s_r.busy)
                s_nxt.addr[15:0] = bus.wdata;
            end
            `DPF_RA_ADDR_HI: begin
              if (!s_r.busy)
                s_nxt.addr[23:16] = bus.wdata[7:0];
            end
            `DPF_RA_BLIM: begin
              if (!s_r.priv)
                s_nxt.blim = bus.wdata; // see R15
            end
            default: begin
            end
          endcase
        end else begin
          case (bus.addr)
            `DPF_RA_CTRL: begin
              s_nxt.rdata = 16'h0000;
              s_nxt.rdata[`DPF_CTRL_START]  = s_r.busy;
              s_nxt.rdata[`DPF_CTRL_ERR]    = s_r.err;
              s_nxt.rdata[`DPF_CTRL_SWDONE] = s_r.swap_done;
              s_nxt.rdata[`DPF_CTRL_P2ACT]  = s_r.active_p2; // see R12
              s_nxt.rdata[`DPF_CTRL_PROT]   = s_r.prot;
              s_nxt.rdata[`DPF_CTRL_PRIV]   = s_r.priv;
              s_nxt.rdata[`DPF_CTRL_OP_MSB:`DPF_CTRL_OP_LSB] = s_r.op;
            end
            `DPF_RA_KEY:     s_nxt.rdata = 16'h0000; // see R16
            `DPF_RA_SRC:     s_nxt.rdata = s_r.src;
            `DPF_RA_ADDR_LO: s_nxt.rdata = s_r.addr[15:0];
            `DPF_RA_ADDR_HI: s_nxt.rdata = {8'h00, s_r.addr[23:16]};
            `DPF_RA_BLIM:    s_nxt.rdata = s_r.blim;
            default:         s_nxt.rdata = 16'h0000;
          endcase
        end
      end
      if (bus.swap_instr) begin
        // Swapping under a running operation would retarget it, so
        // that case is refused like a missing unlock
        if (s_r.ul == dpf_pkg::DPF_UL_ARMED && !s_r.busy) begin
          // Only the partition map flips; nothing else is reloaded
          s_nxt.active_p2 = ~s_r.active_p2; // see R8, see R11
          s_nxt.swap_done = 1'b1;           // see R12
        end
        // Otherwise a plain no-operation
        s_nxt.ul = dpf_pkg::DPF_UL_IDLE; // see R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.ul        <= dpf_pkg::DPF_UL_IDLE;
      s_r.src       <= `DPF_RST_SRC;
      s_r.blim      <= `DPF_RST_BLIM;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign bus.ack           = s_r.ack;
  assign bus.rdata         = s_r.rdata;
  assign bus.dev_busy      = s_r.busy;
  assign bus.dev_swap_done = s_r.swap_done;
  assign bus.dev_active_p2 = s_r.active_p2;
  assign active_p2         = s_r.active_p2;
  assign flash_page_erase  = s_r.ers_page;
  assign flash_part_erase  = s_r.ers_part;
  assign flash_row_prog    = s_r.prog_row;
  assign flash_op_part2    = s_r.op_part2;
  assign flash_op_addr     = s_r.addr;
  assign flash_src_addr    = s_r.src;
  assign boot_limit        = s_r.blim;

endmodule

/* File: logic/dpf_host.sv */
`timescale 1ns/1ps
`include "dpf_defines.svh"
module dpf_host (
  input  wire logic        pclk,    // System clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        ce,      // Clock enable
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic [31:0]      prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error, unmapped address
  output logic             irq,     // Interrupt, level
  dpf_if.host              bus      // Device side
);

  dpf_pkg::dpf_host_st_t s_r;
  dpf_pkg::dpf_host_st_t s_nxt;

  always_comb begin
    logic       acc;
    logic       idle;
    logic [2:0] ev;
    logic [2:0] clr;
    acc  = psel && penable && !s_r.pready;
    idle = (s_r.st == dpf_pkg::DPF_H_IDLE);
    ev   = 3'h0;
    clr  = 3'h0;
    s_nxt = s_r;
    s_nxt.req     = 1'b0;
    s_nxt.swap    = 1'b0;
    s_nxt.jump    = 1'b0;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.busy_q  = bus.dev_busy;
    s_nxt.swap_q  = bus.dev_swap_done;
    case (s_r.st)
      dpf_pkg::DPF_H_WAIT: begin
        if (bus.ack) begin
          s_nxt.last_rd = bus.rdata;
          s_nxt.st      = dpf_pkg::DPF_H_IDLE;
          ev[`DPF_IRQ_DONE] = 1'b1;
        end
      end
      dpf_pkg::DPF_H_SWAP: begin
        s_nxt.jump = 1'b1; // see R8
        s_nxt.st   = dpf_pkg::DPF_H_IDLE;
        ev[`DPF_IRQ_DONE] = 1'b1;
      end
      default: begin
      end
    endcase
    if (acc) begin
      s_nxt.prdata = 32'h0000_0000;
      case (paddr)
        `DPF_HA_WRITE, `DPF_HA_READ, `DPF_HA_SWAP: begin
          // Commands stall the bus until the previous one has finished
          if (!pwrite) begin
            s_nxt.pready = 1'b1;
          end else if (idle) begin
            s_nxt.pready = 1'b1;
            if (paddr == `DPF_HA_SWAP) begin
              s_nxt.swap = 1'b1;
              s_nxt.st   = dpf_pkg::DPF_H_SWAP;
            end else begin
              s_nxt.req  = 1'b1;
              s_nxt.wr   = (paddr == `DPF_HA_WRITE);
              s_nxt.addr = pwdata[`DPF_HC_ADDR_MSB:`DPF_HC_ADDR_LSB];
              s_nxt.data = pwdata[15:0];
              if (pwdata[`DPF_HC_INACT_BIT] &&
                  s_nxt.addr == `DPF_RA_ADDR_HI)
                s_nxt.data = pwdata[15:0] + `DPF_PART_OFS_HI; // see R3
              s_nxt.st   = dpf_pkg::DPF_H_WAIT;
            end
          end
        end
        `DPF_HA_STATUS: begin
          s_nxt.pready = 1'b1;
          s_nxt.prdata = {13'h0000, !idle, bus.dev_busy,
                          bus.dev_active_p2, s_r.last_rd};
        end
        `DPF_HA_IRQ_STAT: begin
          s_nxt.pready = 1'b1;
          s_nxt.prdata = {29'h0000_0000, s_r.irq_st};
        end
        `DPF_HA_IRQ_CLR: begin
          s_nxt.pready = 1'b1;
          if (pwrite)
            clr = pwdata[2:0];
        end
        `DPF_HA_IRQ_EN: begin
          s_nxt.pready = 1'b1;
          s_nxt.prdata = {29'h0000_0000, s_r.irq_en};
          if (pwrite)
            s_nxt.irq_en = pwdata[2:0];
        end
        default: begin
          s_nxt.pready  = 1'b1;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    ev[`DPF_IRQ_OPEND] = s_r.busy_q && !bus.dev_busy;
    ev[`DPF_IRQ_SWAP]  = bus.dev_swap_done && !s_r.swap_q; // see R12
    // A new event beats a clear in the same cycle
    s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
    s_nxt.irq    = |(s_nxt.irq_st & s_nxt.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r    <= '0;
      s_r.st <= dpf_pkg::DPF_H_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign irq            = s_r.irq;
  assign bus.req        = s_r.req;
  assign bus.wr         = s_r.wr;
  assign bus.addr       = s_r.addr;
  assign bus.wdata      = s_r.data;
  assign bus.swap_instr = s_r.swap;
  assign bus.jump_instr = s_r.jump;

endmodule

/* File: tb/dpf_props.sv */
`timescale 1ns/1ps
module dpf_props #(
  parameter int OP_CYCLES = 16
) (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset, low
  input wire logic        req,           // Access strobe
  input wire logic        wr,            // Write access
  input wire logic [2:0]  addr,          // Register index
  input wire logic [15:0] wdata,         // Write data
  input wire logic        ack,           // Answer
  input wire logic [15:0] rdata,         // Read data
  input wire logic        swap_instr,    // Swap instruction
  input wire logic        jump_instr,    // Following jump
  input wire logic        dev_busy,      // Operation running
  input wire logic        dev_swap_done, // Swap done flag
  input wire logic        dev_active_p2  // Partition 2 active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       got1_r;
  logic       armed_r;
  logic [7:0] run_r;
  logic       k55;
  logic       kaa;
  assign k55 = req && wr && addr == 3'h1 && wdata[7:0] == 8'h55;
  assign kaa = req && wr && addr == 3'h1 && wdata[7:0] == 8'haa;
  // Own copy of the unlock state, so a refused swap can be recognised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got1_r  <= 1'b0;
      armed_r <= 1'b0;
      run_r   <= 8'h00;
    end else begin
      if (req || swap_instr) begin
        got1_r  <= k55;
        armed_r <= kaa && got1_r;
      end
      run_r <= dev_busy ? run_r + 8'h01 : 8'h00;
    end
  end
  sequence s_quiet;
    (!req && !swap_instr) throughout (1'b1 ##[0:30] 1'b1);
  endsequence
  sequence s_unlock;
    k55 ##1 s_quiet ##1 kaa ##1 s_quiet ##1 (swap_instr && !dev_busy);
  endsequence
  AST_ACK_NEXT: assert property (req |=> ack)
    else $error("request not answered in one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(req))
    else $error("answer without request");
  AST_KEY_READ_ZERO: assert property (
    req && !wr && addr == 3'h1 |=> rdata == 16'h0000)
    else $error("key register read not zero");
  AST_PART_ERASE: assert property (
    req && wr && addr == 3'h0 && wdata[15] && wdata[3:0] == 4'h4 &&
    !dev_busy && !dev_active_p2 |=> dev_busy)
    else $error("partition erase did not start");
  AST_BUSY_LEN: assert property (
    $fell(dev_busy) |-> run_r == 8'(OP_CYCLES))
    else $error("busy length wrong");
  AST_JUMP: assert property (swap_instr |=> jump_instr)
    else $error("jump did not follow swap");
  AST_SWAP: assert property (
    s_unlock |=> dev_swap_done && dev_active_p2 != $past(dev_active_p2))
    else $error("unlocked swap did not exchange partitions");
  AST_SWAP_NOP: assert property (
    swap_instr && !armed_r |=> $stable(dev_active_p2))
    else $error("locked swap changed partition");
  AST_DONE_HOLD: assert property (
    dev_swap_done && !(req && wr && addr == 3'h0 && !wdata[11])
    |=> dev_swap_done)
    else $error("done flag dropped without clear");
endmodule

/* File: tb/dual_partition_flash_swap_tb.sv */
`timescale 1ns/1ps
`include "dpf_defines.svh"
module dual_partition_flash_swap_tb;
  localparam int OPC = 40;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ce;
  logic        prot;
  logic        priv;
  logic [23:0] w1;
  logic [23:0] w2;
  logic        p2;
  logic        bz;
  logic [15:0] v;
  logic        ap;
  logic        fo2;
  logic        fpe;
  logic        fae;
  logic        frp;
  logic [2:0]  fpv;
  logic [23:0] fa;
  logic [15:0] fs;
  logic [15:0] fb;
  logic [35:0] nt;
  logic [35:0] q[$];
  int          n_mismatch;
  int          n_tests;

  dpf_if bus_if ();
  dpf_dev #(.OP_CYCLES(OPC)) i_dpf_dev (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .seq_word_p1(w1), .seq_word_p2(w2),
    .mode_protected(prot), .mode_privileged(priv), .bus(bus_if.dev),
    .active_p2(ap), .flash_page_erase(fpe), .flash_part_erase(fae),
    .flash_row_prog(frp), .flash_op_part2(fo2), .flash_op_addr(fa),
    .flash_src_addr(fs), .boot_limit(fb)
  );
  dpf_host i_dpf_host (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .bus(bus_if.host)
  );
  dpf_props #(.OP_CYCLES(OPC)) i_dpf_props (
    .pclk(pclk), .presetn(presetn), .req(bus_if.req), .wr(bus_if.wr),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
    .rdata(bus_if.rdata), .swap_instr(bus_if.swap_instr),
    .jump_instr(bus_if.jump_instr), .dev_busy(bus_if.dev_busy),
    .dev_swap_done(bus_if.dev_swap_done),
    .dev_active_p2(bus_if.dev_active_p2)
  );

  always #5 pclk = ~pclk;

  // Last start pulse seen: page erase, partition erase, row program
  always @(posedge pclk) begin
    if (fpe || fae || frp) fpv <= {fpe, fae, frp};
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: pin got %h want %h", $time, g, e);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Note: [35] check irq, [34] irq, [33] check data, [32] pslverr
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [35:0] n);
    int k;
    q.push_back(n);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 64) begin
      n_mismatch++;
      $display("ERROR %0t: no pready", $time);
      results();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 36'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, {4'b0010, e});
  endtask

  task automatic cmd(input logic [2:0] i, input logic [15:0] d,
                     input logic h);
    wr(`DPF_HA_WRITE, {12'h0, h, i, d});
  endtask

  // Host busy is expected clear: the read command has finished by then
  task automatic dev_rd(input logic [2:0] i, input logic [15:0] e);
    wr(`DPF_HA_READ, {13'h0, i, 16'h0});
    rd(`DPF_HA_STATUS, {14'h0, bz, p2, e});
  endtask

  task automatic boot(input logic [23:0] a, input logic [23:0] b,
                      input logic pr, input logic pv);
    presetn <= 1'b0;
    w1      <= a;
    w2      <= b;
    prot    <= pr;
    priv    <= pv;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // A set bad flag breaks the complement half
  function automatic logic [23:0] sw(input logic [11:0] n,
                                     input logic bad);
    return {~n ^ {bad, 11'h0}, n};
  endfunction

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      nt = q.pop_front();
      n_tests++;
      if (pslverr !== nt[32] || (nt[33] && prdata !== nt[31:0]) ||
          (nt[35] && irq !== nt[34])) begin
        n_mismatch++;
        $display("ERROR %0t: at %h got %h", $time, paddr, prdata);
      end
    end
  end

  initial begin
    logic [11:0] a;
    logic [11:0] b;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ce = 1'b1;
    prot = 1'b0;
    priv = 1'b0;
    w1 = 24'h0;
    w2 = 24'h0;
    p2 = 1'b0;
    bz = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(32'h94613f5c));
    a = 12'($urandom_range(2000, 0));
    b = a + 12'($urandom_range(1000, 1));
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: boot(sw(a, 1'b0), sw(b, 1'b0), 1'b0, 1'b0);
        1: boot(sw(b, 1'b0), sw(a, 1'b0), 1'b0, 1'b0);
        2: boot(sw(a, 1'b1), sw(b, 1'b0), 1'b0, 1'b0);
        3: boot(sw(b, 1'b0), sw(a, 1'b1), 1'b0, 1'b0);
        4: boot(sw(a, 1'b1), sw(b, 1'b1), 1'b0, 1'b0);
        default: boot(sw(a, 1'b0), sw(a, 1'b0), 1'b0, 1'b0);
      endcase
      rd(`DPF_HA_STATUS, {15'h0, i == 1 || i == 2, 16'h0});
    end
    v = 16'($urandom);
    cmd(3'h2, v, 1'b0);
    dev_rd(3'h2, v);
    chk(fs, v);
    cmd(3'h1, 16'h00a5, 1'b0);
    dev_rd(3'h1, 16'h0000);
    apb(8'h1c, 1'b0, 32'h0, {4'b0011, 32'h0});
    cmd(3'h0, 16'h8004, 1'b0);
    bz = 1'b1;
    dev_rd(3'h2, v);
    bz = 1'b0;
    repeat (OPC) @(posedge pclk);
    chk({fo2, fpv}, 4'b1010);
    dev_rd(3'h0, 16'h0004);
    cmd(3'h3, 16'($urandom), 1'b0);
    cmd(3'h4, 16'h0012, 1'b1);
    dev_rd(3'h4, 16'h0052);
    chk(fa[23:16], 8'h52);
    cmd(3'h0, 16'h8003, 1'b0);
    repeat (OPC) @(posedge pclk);
    chk({fo2, fpv}, 4'b1100);
    cmd(3'h0, 16'h8002, 1'b0);
    repeat (OPC) @(posedge pclk);
    dev_rd(3'h0, 16'h0002);
    chk({fo2, fpv}, 4'b1001);
    apb(`DPF_HA_IRQ_STAT, 1'b0, 32'h0, {4'b1010, 32'h3});
    wr(`DPF_HA_IRQ_EN, 32'h1);
    apb(`DPF_HA_IRQ_STAT, 1'b0, 32'h0, {4'b1110, 32'h3});
    wr(`DPF_HA_IRQ_CLR, 32'h3);
    apb(`DPF_HA_IRQ_STAT, 1'b0, 32'h0, {4'b1010, 32'h0});
    wr(`DPF_HA_IRQ_EN, 32'h0);
    cmd(3'h1, 16'h0055, 1'b0);
    cmd(3'h1, 16'h00aa, 1'b0);
    wr(`DPF_HA_SWAP, 32'h0);
    p2 = 1'b1;
    dev_rd(3'h0, 16'h0c02);
    chk(ap, 1'b1);
    wr(`DPF_HA_IRQ_EN, 32'h4);
    apb(`DPF_HA_IRQ_STAT, 1'b0, 32'h0, {4'b1110, 32'h5});
    dev_rd(3'h2, v);
    cmd(3'h0, 16'h0002, 1'b0);
    dev_rd(3'h0, 16'h0402);
    cmd(3'h1, 16'h0055, 1'b0);
    cmd(3'h2, v, 1'b0);
    cmd(3'h1, 16'h00aa, 1'b0);
    wr(`DPF_HA_SWAP, 32'h0);
    dev_rd(3'h0, 16'h0402);
    wr(`DPF_HA_SWAP, 32'h0);
    dev_rd(3'h0, 16'h0402);
    cmd(3'h1, 16'h0055, 1'b0);
    cmd(3'h1, 16'h00aa, 1'b0);
    wr(`DPF_HA_SWAP, 32'h0);
    p2 = 1'b0;
    dev_rd(3'h0, 16'h0802);
    cmd(3'h4, 16'h0012, 1'b0);
    cmd(3'h0, 16'h8002, 1'b0);
    dev_rd(3'h0, 16'h4002);
    boot(sw(b, 1'b0), sw(a, 1'b0), 1'b1, 1'b1);
    p2 = 1'b1;
    cmd(3'h0, 16'h8004, 1'b0);
    dev_rd(3'h0, 16'h4704);
    chk({fo2, fpv}, 4'b0001);
    cmd(3'h5, 16'($urandom) | 16'h0001, 1'b0);
    dev_rd(3'h5, 16'h0000);
    chk(fb, 16'h0000);
    results();
  end
endmodule
